// ---- pkg/rvq_cfg.svh ----
// Constants of the ring validation qualifier: offsets, fields, resets, timing
//Contract
//- Qualification runs only while the check enable bit is 1; at 0 the ring is passed unqualified.
//- Each ring event reloads a countdown from the assertion-time field, which then falls per tick.
//- A second or later event arriving after the countdown expired invalidates the ring; once in ST_VALID the code ignores it and the ring stays valid.
//- Events closer than assertion time minus max margin, in 2 ms steps, do not qualify.
//- After reset the control register reads 0001_1001.
//- Two events are expected per ring period, one per half cycle of the waveform.
//- A ring is valid only after staying in limits for the confirmation time, 100 ms to 1024 ms.
//- The ring ends once the timeout, 128 ms steps up to 1920 ms, passes after the last event.
//- A delay of 0 to 1792 ms in 256 ms steps separates validation from indication.
`ifndef RVQ_CFG_SVH
`define RVQ_CFG_SVH

`define RVQ_ADDR_CTRL1 8'h16
`define RVQ_ADDR_CTRL2 8'h17
`define RVQ_ADDR_CTRL3 8'h18
`define RVQ_ADDR_STATUS 8'h20
`define RVQ_ADDR_MASK 8'h21
`define RVQ_ADDR_STATE 8'h22

`define RVQ_CTRL1_RST 8'h00
`define RVQ_CTRL2_RST 8'h08
`define RVQ_CTRL3_RST 8'h19
`define RVQ_CTRL3_WMASK 8'hBF

`define RVQ_EN_BIT 7
`define RVQ_DLYH_BIT 7

`define RVQ_STS_VALID 0
`define RVQ_STS_END 1
`define RVQ_STS_INVAL 2

`define RVQ_CLK_NS 20
`define RVQ_TICK_MS 2
`define RVQ_TICK_NS 2000000
`define RVQ_PRE_W 17

`define RVQ_CONF0_MS 100
`define RVQ_CONF1_MS 150
`define RVQ_CONF2_MS 200
`define RVQ_CONF3_MS 256
`define RVQ_CONF4_MS 384
`define RVQ_CONF5_MS 512
`define RVQ_CONF6_MS 640
`define RVQ_CONF7_MS 1024
`define RVQ_TO_STEP_MS 128
`define RVQ_DLY_STEP_MS 256

`endif

// ---- pkg/rvq_pkg.sv ----
// Types of the ring validation qualifier
`include "rvq_cfg.svh"
package rvq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_QUAL,
        ST_DELAY,
        ST_VALID
    } rvq_state_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [2:0] mask;
        logic [2:0] sts;
        rvq_state_e state;
        logic [5:0] as_cnt;
        logic [9:0] conf_cnt;
        logic [9:0] to_cnt;
        logic [9:0] dly_cnt;
        logic ring_act;
        logic valid;
        logic irq;
        logic [7:0] rd_data;
    } rvq_top_s;

    typedef struct packed {
        logic [`RVQ_PRE_W-1:0] cnt;
        logic tick;
    } rvq_pre_s;

endpackage

// ---- pkg/rvq_tick_if.sv ----
// Clock enable and 2 ms tick between the qualifier and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface rvq_tick_if;
    logic ce;
    logic tick;
    modport gen (input ce, output tick);
    modport use_side (output ce, input tick);
endinterface
`default_nettype wire

// ---- rtl/rvq_prescaler.sv ----
// Prescaler that makes the 2 ms time base tick
`timescale 1ns/1ps
`default_nettype none
`include "rvq_cfg.svh"
module rvq_prescaler
    import rvq_pkg::*;
#(
    parameter int P_TICK_CYC = `RVQ_TICK_NS / `RVQ_CLK_NS
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Tick link
    rvq_tick_if.gen tif
);

    rvq_pre_s s_r;
    rvq_pre_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (tif.ce) begin
            s_nxt.tick = 1'b0;
            if (s_r.cnt == `RVQ_PRE_W'(P_TICK_CYC - 1)) begin
                s_nxt.cnt = '0;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + `RVQ_PRE_W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tif.tick = s_r.tick;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // Ticks are never closer than three cycles for any sane divider
    property p_tick_gap;
        s_r.tick && tif.ce |=> !s_r.tick ##1 !s_r.tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing too short");

endmodule
`default_nettype wire

// ---- rtl/rvq_top.sv ----
// Ring validation qualifier: register file, event timing and ring indication
`timescale 1ns/1ps
`default_nettype none
`include "rvq_cfg.svh"
module rvq_top
    import rvq_pkg::*;
#(
    parameter int P_TICK_CYC = `RVQ_TICK_NS / `RVQ_CLK_NS
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Line-side threshold event pin
    input wire logic i_ring_event,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    // Indications
    output logic o_ring_valid,
    output logic o_irq
);

    rvq_top_s s_r;
    rvq_top_s s_nxt;
    rvq_tick_if tif ();

    logic en;
    logic ev;
    logic tick;
    logic bad;
    logic ring_end;
    logic [5:0] ras;
    logic [5:0] rmx;
    logic [9:0] conf_tk;
    logic [9:0] to_tk;
    logic [9:0] dly_tk;
    logic [2:0] set;
    logic [2:0] clr;

    assign tif.ce = i_ce;

    rvq_prescaler #(
        .P_TICK_CYC(P_TICK_CYC)
    ) u_pre (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .tif(tif)
    );

    function automatic logic [9:0] conf_ticks(input logic [2:0] code);
        logic [9:0] t;
        case (code)
            3'h0: t = 10'(`RVQ_CONF0_MS / `RVQ_TICK_MS);
            3'h1: t = 10'(`RVQ_CONF1_MS / `RVQ_TICK_MS);
            3'h2: t = 10'(`RVQ_CONF2_MS / `RVQ_TICK_MS);
            3'h3: t = 10'(`RVQ_CONF3_MS / `RVQ_TICK_MS);
            3'h4: t = 10'(`RVQ_CONF4_MS / `RVQ_TICK_MS);
            3'h5: t = 10'(`RVQ_CONF5_MS / `RVQ_TICK_MS);
            3'h6: t = 10'(`RVQ_CONF6_MS / `RVQ_TICK_MS);
            default: t = 10'(`RVQ_CONF7_MS / `RVQ_TICK_MS);
        endcase
        return t;
    endfunction

    always_comb begin
        s_nxt = s_r;
        en = s_r.ctrl3[`RVQ_EN_BIT];
        ras = s_r.ctrl3[5:0];
        rmx = s_r.ctrl1[5:0];
        conf_tk = conf_ticks(s_r.ctrl2[2:0]);
        // Timeout code zero is forbidden; it is taken as one step
        to_tk = 10'(`RVQ_TO_STEP_MS / `RVQ_TICK_MS) *
                ((s_r.ctrl2[6:3] == 4'h0) ? 10'h001 : {6'h00, s_r.ctrl2[6:3]});
        dly_tk = 10'(`RVQ_DLY_STEP_MS / `RVQ_TICK_MS) *
                 {7'h00, s_r.ctrl2[`RVQ_DLYH_BIT], s_r.ctrl1[7:6]};
        tick = tif.tick;
        // One event per threshold crossing, i.e. per half cycle of ringing
        ev = s_r.sync2 & ~s_r.prev;
        // Expired countdown or too short spacing both spoil the ring
        bad = (s_r.as_cnt == 6'h00) || (s_r.as_cnt > rmx);
        ring_end = s_r.ring_act && !ev && (s_r.to_cnt >= to_tk);
        set = 3'h0;
        clr = 3'h0;
        if (i_ce) begin
            s_nxt.sync1 = i_ring_event;
            s_nxt.sync2 = s_r.sync1;
            s_nxt.prev = s_r.sync2;
            s_nxt.rd_data = 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `RVQ_ADDR_CTRL1: s_nxt.rd_data = s_r.ctrl1;
                    `RVQ_ADDR_CTRL2: s_nxt.rd_data = s_r.ctrl2;
                    `RVQ_ADDR_CTRL3: s_nxt.rd_data = s_r.ctrl3;
                    `RVQ_ADDR_STATUS: begin
                        s_nxt.rd_data = {5'h00, s_r.sts};
                        clr = 3'h7;
                    end
                    `RVQ_ADDR_MASK: s_nxt.rd_data = {5'h00, s_r.mask};
                    `RVQ_ADDR_STATE: s_nxt.rd_data = {5'h00, s_r.valid, s_r.ring_act,
                                                      (s_r.as_cnt == 6'h00)};
                    default: s_nxt.rd_data = 8'h00;
                endcase
            end
            if (i_wr) begin
                case (i_addr)
                    `RVQ_ADDR_CTRL1: s_nxt.ctrl1 = i_wr_data;
                    `RVQ_ADDR_CTRL2: s_nxt.ctrl2 = i_wr_data;
                    // Reserved bit kept at zero whatever software writes
                    `RVQ_ADDR_CTRL3: s_nxt.ctrl3 = i_wr_data & `RVQ_CTRL3_WMASK;
                    `RVQ_ADDR_MASK: s_nxt.mask = i_wr_data[2:0];
                    default: s_nxt.mask = s_nxt.mask;
                endcase
            end
            if (tick && s_r.as_cnt != 6'h00) begin
                s_nxt.as_cnt = s_r.as_cnt - 6'h01;
            end
            if (tick && s_r.ring_act && s_r.to_cnt != 10'h3FF) begin
                s_nxt.to_cnt = s_r.to_cnt + 10'h001;
            end
            if (ev) begin
                s_nxt.as_cnt = ras;
                s_nxt.to_cnt = 10'h000;
                s_nxt.ring_act = 1'b1;
                if (!en && !s_r.valid) begin
                    s_nxt.valid = 1'b1;
                    set[`RVQ_STS_VALID] = 1'b1;
                end
            end
            if (en) begin
                case (s_r.state)
                    ST_IDLE: begin
                        if (ev) begin
                            s_nxt.state = ST_QUAL;
                            s_nxt.conf_cnt = 10'h000;
                        end
                    end
                    ST_QUAL: begin
                        if (ev && bad) begin
                            s_nxt.conf_cnt = 10'h000;
                            set[`RVQ_STS_INVAL] = 1'b1;
                        end else if (s_r.as_cnt == 6'h00) begin
                            // Silence past the countdown is no ring, so confirmation restarts
                            s_nxt.conf_cnt = 10'h000;
                        end else if (tick) begin
                            s_nxt.conf_cnt = s_r.conf_cnt + 10'h001;
                            if (s_r.conf_cnt + 10'h001 >= conf_tk) begin
                                s_nxt.state = ST_DELAY;
                                s_nxt.dly_cnt = 10'h000;
                            end
                        end
                    end
                    ST_DELAY: begin
                        if (ev && bad) begin
                            s_nxt.state = ST_QUAL;
                            s_nxt.conf_cnt = 10'h000;
                            set[`RVQ_STS_INVAL] = 1'b1;
                        end else if (s_r.dly_cnt >= dly_tk) begin
                            s_nxt.state = ST_VALID;
                            s_nxt.valid = 1'b1;
                            set[`RVQ_STS_VALID] = 1'b1;
                        end else if (tick) begin
                            s_nxt.dly_cnt = s_r.dly_cnt + 10'h001;
                        end
                    end
                    ST_VALID: s_nxt.state = ST_VALID;
                    default: s_nxt.state = ST_IDLE;
                endcase
            end else begin
                s_nxt.state = ST_IDLE;
            end
            if (ring_end) begin
                s_nxt.state = ST_IDLE;
                s_nxt.ring_act = 1'b0;
                s_nxt.valid = 1'b0;
                set[`RVQ_STS_END] = s_r.valid;
            end
            // New events beat a clear by read in the same cycle
            s_nxt.sts = (s_r.sts & ~clr) | set;
            s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.state <= ST_IDLE;
            s_r.ctrl1 <= `RVQ_CTRL1_RST;
            s_r.ctrl2 <= `RVQ_CTRL2_RST;
            s_r.ctrl3 <= `RVQ_CTRL3_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rd_data = s_r.rd_data;
    assign o_ring_valid = s_r.valid;
    assign o_irq = s_r.irq;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_rst_val;
        $past(i_rst) |-> s_r.ctrl3 == 8'h19 && o_rd_data == 8'h00;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("control reset value wrong");

    property p_bypass;
        !en && i_ce |=> s_r.state == ST_IDLE;
    endproperty
    a_bypass: assert property (p_bypass) else $error("qualifier ran while disabled");

    property p_reload;
        ev && i_ce |=> s_r.as_cnt == $past(ras);
    endproperty
    a_reload: assert property (p_reload) else $error("countdown not reloaded");

    property p_decr;
        tick && !ev && i_ce && s_r.as_cnt != 6'h00 |=> s_r.as_cnt == $past(s_r.as_cnt) - 6'h01;
    endproperty
    a_decr: assert property (p_decr) else $error("countdown did not fall");

    property p_late;
        en && i_ce && ev && s_r.state == ST_QUAL && s_r.as_cnt == 6'h00
            |=> s_r.sts[`RVQ_STS_INVAL] && s_r.conf_cnt == 10'h000;
    endproperty
    a_late: assert property (p_late) else $error("late event not invalidated");

    property p_close;
        en && i_ce && ev && (s_r.state == ST_QUAL || s_r.state == ST_DELAY) && s_r.as_cnt > rmx
            |=> s_r.state == ST_QUAL && s_r.sts[`RVQ_STS_INVAL];
    endproperty
    a_close: assert property (p_close) else $error("close event not rejected");

    property p_confirm;
        en && $rose(s_r.state == ST_DELAY) |-> $past(s_r.conf_cnt) + 10'h001 >= $past(conf_tk);
    endproperty
    a_confirm: assert property (p_confirm) else $error("confirmed too early");

    property p_delay;
        $rose(s_r.valid) && $past(en) |-> $past(s_r.state) == ST_DELAY
            && $past(s_r.dly_cnt) >= $past(dly_tk);
    endproperty
    a_delay: assert property (p_delay) else $error("valid without delay");

    property p_end;
        $fell(s_r.valid) |-> $past(ring_end) && $past(s_r.to_cnt) >= $past(to_tk);
    endproperty
    a_end: assert property (p_end) else $error("valid dropped without timeout");

    property p_irq;
        ##1 o_irq == |(s_r.sts & s_r.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

endmodule
`default_nettype wire

// ---- verif/rvq_line_model.sv ----
// Line-side model that raises threshold events on the ring pin
`timescale 1ns/1ps
`default_nettype none
module rvq_line_model (
    // Clock
    input wire logic i_clk,
    // Threshold event pin
    output logic o_pin
);
    initial o_pin = 1'b0;

    // One pulse per half cycle, held 3 cycles so the 2-stage sync sees both levels
    task automatic send(int n, int gap_ticks, int tick_cyc);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (3) @(posedge i_clk);
            o_pin <= 1'b0;
            repeat (gap_ticks * tick_cyc - 4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench of the ring validation qualifier
`timescale 1ns/1ps
`default_nettype none
`include "rvq_cfg.svh"
module tb;
    import rvq_pkg::*;
    localparam int TC = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ev;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdat;
    logic valid;
    logic irq;
    logic [15:0] q[$];
    logic [15:0] note;
    logic [7:0] rv;
    int errors = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    rvq_top #(.P_TICK_CYC(TC)) rvq_top_i (
        .i_ref_clk(clk),
        .i_rst(rst),
        .i_ce(ce),
        .i_ring_event(ev),
        .i_addr(addr),
        .i_wr_data(wdat),
        .i_wr(wr),
        .i_rd(rd),
        .o_rd_data(rdat),
        .o_ring_valid(valid),
        .o_irq(irq)
    );

    rvq_line_model rvq_line_model_i (
        .i_clk(clk),
        .o_pin(ev)
    );

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            if (q.size() == 0) begin
                check("read queue", 8'h01, 8'h00);
            end else begin
                note = q.pop_front();
                check("read data", note[15:8], rdat & note[7:0]);
            end
        end
    end

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Mask picks the bits whose value this test can predict
    task automatic rd_reg(logic [7:0] a, logic [7:0] e, logic [7:0] m);
        @(posedge clk);
        q.push_back({e & m, m});
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic chk_pin(string what, logic exp, logic got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic wait_valid(logic lvl, int lim);
        int n = 0;
        while (valid !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk_pin("ring valid", lvl, valid);
        if (valid !== lvl) report_and_stop();
    endtask

    initial begin
        void'($urandom(20));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`RVQ_ADDR_CTRL3, `RVQ_CTRL3_RST, 8'hFF);
        rd_reg(`RVQ_ADDR_CTRL1, `RVQ_CTRL1_RST, 8'hFF);
        rd_reg(`RVQ_ADDR_CTRL2, `RVQ_CTRL2_RST, 8'hFF);
        rd_reg(8'h55, 8'h00, 8'hFF);
        rv = 8'($urandom());
        wr_reg(`RVQ_ADDR_CTRL1, rv);
        rd_reg(`RVQ_ADDR_CTRL1, rv, 8'hFF);
        // Writes while the clock enable is low must be lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`RVQ_ADDR_CTRL1, ~rv);
        ce <= 1'b1;
        rd_reg(`RVQ_ADDR_CTRL1, rv, 8'hFF);
        $display("test registers done");

        wr_reg(`RVQ_ADDR_CTRL3, 8'h19);
        rvq_line_model_i.send(1, 1, TC);
        wait_valid(1'b1, 40);
        chk_pin("irq masked", 1'b0, irq);
        rd_reg(`RVQ_ADDR_STATUS, 8'h01, 8'h01);
        repeat (55 * TC) @(negedge clk);
        chk_pin("ring valid held", 1'b1, valid);
        wait_valid(1'b0, 20 * TC);
        rd_reg(`RVQ_ADDR_STATUS, 8'h02, 8'h02);
        $display("test bypass done");

        // Delay code 1 and timeout code 3, so the ring outlasts confirmation plus delay
        wr_reg(`RVQ_ADDR_CTRL1, 8'h4A);
        wr_reg(`RVQ_ADDR_CTRL2, 8'h18);
        wr_reg(`RVQ_ADDR_MASK, 8'h01);
        rd_reg(`RVQ_ADDR_MASK, 8'h01, 8'hFF);
        wr_reg(`RVQ_ADDR_CTRL3, 8'h99);
        fork
            rvq_line_model_i.send(6, 20, TC);
            begin
                repeat (150 * TC) @(negedge clk);
                chk_pin("ring valid early", 1'b0, valid);
                wait_valid(1'b1, 40 * TC);
                @(negedge clk);
                chk_pin("irq", 1'b1, irq);
            end
        join
        rd_reg(`RVQ_ADDR_STATUS, 8'h01, 8'h05);
        repeat (3) @(negedge clk);
        chk_pin("irq cleared", 1'b0, irq);
        wait_valid(1'b0, 200 * TC);
        rd_reg(`RVQ_ADDR_STATUS, 8'h02, 8'h02);
        $display("test qualified ring done");

        wr_reg(`RVQ_ADDR_CTRL2, `RVQ_CTRL2_RST);
        // Too slow first, then too close
        for (int k = 0; k < 2; k++) begin
            rvq_line_model_i.send(k ? 8 : 3, k ? 5 : 30, TC);
            chk_pin("ring valid bad", 1'b0, valid);
            rd_reg(`RVQ_ADDR_STATUS, 8'h04, 8'h04);
            repeat (80 * TC) @(negedge clk);
            wait_valid(1'b0, 100 * TC);
            // No late validation once the events have stopped
            rd_reg(`RVQ_ADDR_STATUS, 8'h00, 8'h07);
            rd_reg(`RVQ_ADDR_STATE, 8'h01, 8'h07);
        end
        $display("test bad spacing done");
        repeat (3) @(posedge clk);
        if (q.size() != 0) check("reads left", 8'h00, 8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
